/* File: hw/sfid_defs.vh */
// Constants of the flash identification, power-down release and secure-sector logic.
// Assumes inclusion by bare name from the design file of the same block.
`ifndef SFID_DEFS_VH
`define SFID_DEFS_VH
`define SFID_OP_RELEASE_ID    8'hAB
`define SFID_OP_MFR_DEV_ID    8'h90
`define SFID_OP_THREE_BYTE_ID 8'h9F
`define SFID_OP_ENTER_SECURE  8'h3A
`define SFID_OP_WRITE_DISABLE 8'h04
`define SFID_OP_SECTOR_ERASE  8'h20
`define SFID_OP_DEEP_SLEEP    8'hB9
`define SFID_OP_STATUS_WRITE  8'h01
`define SFID_OP_PAGE_PROGRAM  8'h02
`define SFID_OP_BLOCK_ERASE   8'hD8
`define SFID_OP_CHIP_ERASE_A  8'hC7
`define SFID_OP_CHIP_ERASE_B  8'h60
`define SFID_ADDR_DEV_FIRST   24'h000001
`define SFID_SECURE_SECTOR    8'hFF
`define SFID_SECURE_BASE      24'h0FF000
`define SFID_SECURE_LAST      24'h0FF0FF
`define SFID_DUMMY_BYTES      3
`define SFID_STATUS_RESET     8'h00
`define SFID_ARRAY_ERASED     8'hFF
`define SFID_BP_CLEAR         3'h0
`define SFID_CLK_MHZ          100
`define SFID_RES1_MAX_NS      3000
`define SFID_RES2_MAX_NS      1800
`define SFID_PUW_MIN_US       1000
`define SFID_RES1_CYCLES      ((`SFID_RES1_MAX_NS * `SFID_CLK_MHZ) / 1000)
`define SFID_RES2_CYCLES      ((`SFID_RES2_MAX_NS * `SFID_CLK_MHZ) / 1000)
`define SFID_PUW_CYCLES       (`SFID_PUW_MIN_US * `SFID_CLK_MHZ)
`endif

/* File: hw/sfid_core.v */
// Identification, deep power-down release, secure-sector mode and power-up write inhibit
// of a serial flash. Assumes an SPI host on select, clock and data pins (mode 0 or 3),
// with the serial clock much slower than clk_in, and an array core that reports busy.
`include "sfid_defs.vh"
module sfid_core #(
   parameter [7:0]  MFR_ID       = 8'h5A,   // Arbitrary value.
   parameter [7:0]  DEV_ID       = 8'h13,   // Arbitrary value.
   parameter [7:0]  MEM_TYPE     = 8'h31,   // Arbitrary value.
   parameter [7:0]  CAPACITY     = 8'h14,   // Arbitrary value.
   parameter [31:0] PUW_CYCLES   = `SFID_PUW_CYCLES,
   parameter [15:0] RES1_CYCLES  = `SFID_RES1_CYCLES,
   parameter [15:0] RES2_CYCLES  = `SFID_RES2_CYCLES
) (
   input  wire        clk_in,
   input  wire        srst_in,
   input  wire        sel_n_in,
   input  wire        sclk_in,
   input  wire        sdi_in,
   input  wire        array_busy_in,
   input  wire [2:0]  block_protection_field_in,
   input  wire        protect_select_bit_in,
   output reg         sdo_out,
   output reg         sdo_oe_n_out,
   output reg         deep_sleep_out,
   output reg         ready_out,
   output reg         secure_mode_out,
   output reg         secure_lock_out,
   output reg         secure_map_out,
   output reg         array_write_ok_out,
   output reg         secure_write_ok_out,
   output reg         lock_program_out,
   output reg         status_write_req_out,
   output reg         deep_sleep_instr_out,
   output reg [7:0]   opcode_out,
   output reg [7:0]   status_view_out
);
   localparam [2:0] ST_OPCODE = 3'h0;
   localparam [2:0] ST_ADDR   = 3'h1;
   localparam [2:0] ST_OUT    = 3'h2;
   localparam [2:0] ST_IGNORE = 3'h3;
   localparam [2:0] ST_DONE   = 3'h4;

   reg  [2:0]  sel_sync_r;
   reg  [2:0]  sclk_sync_r;
   reg  [1:0]  sdi_sync_r;
   reg  [2:0]  state_r;
   reg  [7:0]  op_r;
   reg  [23:0] addr_r;
   reg  [5:0]  bit_cnt_r;
   reg  [23:0] out_sh_r;
   reg  [4:0]  out_cnt_r;
   reg         sleep_r;
   reg         release_pend_r;
   reg  [15:0] wait_cnt_r;
   reg  [31:0] puw_cnt_r;
   reg         wr_ok_r;
   wire        sel_low;
   wire        sel_rise;
   wire        sclk_rise;
   wire        sclk_fall;
   wire        sdi_s;
   wire [7:0]  op_nxt;
   wire        write_block;

   // Only the second and third stages feed logic, the first is a pure synchroniser.
   assign sel_low   = ~sel_sync_r[1];
   assign sel_rise  = sel_sync_r[1] & ~sel_sync_r[2];
   assign sclk_rise = sclk_sync_r[1] & ~sclk_sync_r[2];
   assign sclk_fall = ~sclk_sync_r[1] & sclk_sync_r[2];
   assign sdi_s     = sdi_sync_r[1];
   assign op_nxt    = {op_r[6:0], sdi_s};
   assign write_block = ~wr_ok_r | sleep_r;

   // Ident payload, left justified; the length says how many bits before it repeats.
   function [28:0] ident_load;
      input [7:0]  op;
      input [23:0] addr;
      begin
         if (op == `SFID_OP_THREE_BYTE_ID) begin
            ident_load = {5'd24, MFR_ID, MEM_TYPE, CAPACITY};
         end else if (op == `SFID_OP_MFR_DEV_ID && addr == `SFID_ADDR_DEV_FIRST) begin
            ident_load = {5'd16, DEV_ID, MFR_ID, 8'h00};
         end else if (op == `SFID_OP_MFR_DEV_ID) begin
            ident_load = {5'd16, MFR_ID, DEV_ID, 8'h00};
         end else begin
            ident_load = {5'd8, DEV_ID, 16'h0000};
         end
      end
   endfunction

   always @(posedge clk_in) begin
      if (srst_in) begin
         sel_sync_r  <= 3'h7;
         sclk_sync_r <= 3'h0;
         sdi_sync_r  <= 2'h0;
      end else begin
         sel_sync_r  <= {sel_sync_r[1:0], sel_n_in};
         sclk_sync_r <= {sclk_sync_r[1:0], sclk_in};
         sdi_sync_r  <= {sdi_sync_r[0], sdi_in};
      end
   end

   // Power-up write inhibit; the minimum is used so writes are never early.
   always @(posedge clk_in) begin
      if (srst_in) begin
         puw_cnt_r <= 32'h0000_0000;
         wr_ok_r   <= 1'b0;
      end else if (puw_cnt_r >= PUW_CYCLES - 32'h1) begin
         wr_ok_r   <= 1'b1;
      end else begin
         puw_cnt_r <= puw_cnt_r + 32'h1;
      end
   end

   always @(posedge clk_in) begin
      if (srst_in) begin
         state_r              <= ST_OPCODE;
         op_r                 <= 8'h00;
         addr_r               <= 24'h000000;
         bit_cnt_r            <= 6'h00;
         out_sh_r             <= 24'h000000;
         out_cnt_r            <= 5'h00;
         sleep_r              <= 1'b0;
         release_pend_r       <= 1'b0;
         wait_cnt_r           <= 16'h0000;
         sdo_out              <= 1'b0;
         sdo_oe_n_out         <= 1'b1;
         secure_mode_out      <= 1'b0;
         lock_program_out     <= 1'b0;
         status_write_req_out <= 1'b0;
         deep_sleep_instr_out <= 1'b0;
         opcode_out           <= 8'h00;
      end else begin
         lock_program_out     <= 1'b0;
         status_write_req_out <= 1'b0;
         deep_sleep_instr_out <= 1'b0;
         // Selects are ignored until the wait runs out, so a host that comes back early
         // cannot cut the release delay short.
         if (release_pend_r) begin
            if (wait_cnt_r <= 16'h0001) begin
               release_pend_r <= 1'b0;
               sleep_r        <= 1'b0;
            end else begin
               wait_cnt_r <= wait_cnt_r - 16'h0001;
            end
         end
         if (!sel_low) begin
            sdo_oe_n_out <= 1'b1;
         end
         if (sel_rise) begin
            // Single-opcode instructions take effect only when select rises on a whole byte;
            // a status write needs exactly one data byte, which it then discards.
            if (state_r == ST_OPCODE && bit_cnt_r == 6'd16) begin
               opcode_out <= op_r;
               if (!sleep_r && op_r == `SFID_OP_STATUS_WRITE && !write_block) begin
                  if (secure_mode_out) begin
                     lock_program_out <= 1'b1;
                  end else begin
                     status_write_req_out <= 1'b1;
                  end
               end
            end else if (state_r == ST_OPCODE && bit_cnt_r == 6'd8) begin
               opcode_out <= op_r;
               if (op_r == `SFID_OP_RELEASE_ID && sleep_r && !array_busy_in) begin
                  release_pend_r <= 1'b1;
                  wait_cnt_r     <= RES1_CYCLES;
               end else if (!sleep_r && op_r == `SFID_OP_DEEP_SLEEP && !array_busy_in) begin
                  sleep_r              <= 1'b1;
                  deep_sleep_instr_out <= 1'b1;
               end else if (!sleep_r && op_r == `SFID_OP_ENTER_SECURE) begin
                  secure_mode_out <= 1'b1;
               end else if (!sleep_r && op_r == `SFID_OP_WRITE_DISABLE) begin
                  secure_mode_out <= 1'b0;
               end
            end else if (state_r == ST_OUT && op_r == `SFID_OP_RELEASE_ID && sleep_r) begin
               release_pend_r <= 1'b1;
               wait_cnt_r     <= RES2_CYCLES;
            end
            state_r   <= ST_OPCODE;
            bit_cnt_r <= 6'h00;
         end else if (sel_low && release_pend_r) begin
            state_r <= ST_IGNORE;
         end else if (sel_low && sclk_rise) begin
            case (state_r)
               ST_OPCODE: begin
                  // The opcode freezes after eight bits; decode at select rise and the
                  // repeating identifier both read it long after the opcode byte.
                  if (bit_cnt_r < 6'd8) begin
                     op_r      <= op_nxt;
                     bit_cnt_r <= bit_cnt_r + 6'h01;
                  end
                  if (bit_cnt_r == 6'd7) begin
                     addr_r    <= 24'h000000;
                     bit_cnt_r <= 6'd8;
                     if (sleep_r && op_nxt != `SFID_OP_RELEASE_ID) begin
                        state_r <= ST_IGNORE;
                     end else if (array_busy_in && (op_nxt == `SFID_OP_RELEASE_ID
                              || op_nxt == `SFID_OP_THREE_BYTE_ID)) begin
                        state_r <= ST_IGNORE;
                     end else if (op_nxt == `SFID_OP_THREE_BYTE_ID) begin
                        state_r <= ST_DONE;
                        {out_cnt_r, out_sh_r} <= ident_load(op_nxt, 24'h000000);
                     end else if (op_nxt == `SFID_OP_RELEASE_ID
                              || op_nxt == `SFID_OP_MFR_DEV_ID) begin
                        state_r <= ST_OPCODE;
                     end
                  end else if (bit_cnt_r >= 6'd8) begin
                     // A ninth bit starts the dummy or address bytes.
                     if (op_r == `SFID_OP_RELEASE_ID || op_r == `SFID_OP_MFR_DEV_ID) begin
                        state_r   <= ST_ADDR;
                        addr_r    <= {23'h000000, sdi_s};
                        bit_cnt_r <= 6'd1;
                     end else if (op_r == `SFID_OP_STATUS_WRITE && bit_cnt_r < 6'd16) begin
                        bit_cnt_r <= bit_cnt_r + 6'h01;
                     end else begin
                        state_r <= ST_IGNORE;
                     end
                  end
               end
               ST_ADDR: begin
                  addr_r    <= {addr_r[22:0], sdi_s};
                  bit_cnt_r <= bit_cnt_r + 6'h01;
                  if (bit_cnt_r == 6'd8 * `SFID_DUMMY_BYTES - 6'd1) begin
                     state_r <= ST_DONE;
                     {out_cnt_r, out_sh_r} <= ident_load(op_r, {addr_r[22:0], sdi_s});
                  end
               end
               ST_DONE: begin
                  state_r <= ST_OUT;
               end
               default: begin
                  state_r <= state_r;
               end
            endcase
         end else if (sel_low && sclk_fall && (state_r == ST_DONE || state_r == ST_OUT)) begin
            // Output changes on falling edges and wraps to repeat the identifier.
            state_r      <= ST_OUT;
            sdo_oe_n_out <= 1'b0;
            sdo_out      <= out_sh_r[23];
            if (out_cnt_r == 5'd1) begin
               {out_cnt_r, out_sh_r} <= ident_load(op_r, addr_r);
            end else begin
               out_sh_r  <= {out_sh_r[22:0], 1'b0};
               out_cnt_r <= out_cnt_r - 5'd1;
            end
         end
      end
   end

   // Write permissions seen by the array engine; lock is the protect-select bit while in secure mode.
   // The status view is a registered copy of the external status bits, taken every clock,
   // so it lags the register that the array engine holds by one clock.
   always @(posedge clk_in) begin
      if (srst_in) begin
         deep_sleep_out      <= 1'b0;
         ready_out           <= 1'b0;
         secure_lock_out     <= 1'b0;
         secure_map_out      <= 1'b0;
         array_write_ok_out  <= 1'b0;
         secure_write_ok_out <= 1'b0;
         status_view_out     <= `SFID_STATUS_RESET;
      end else begin
         deep_sleep_out      <= sleep_r;
         ready_out           <= ~sleep_r & ~release_pend_r;
         secure_lock_out     <= secure_mode_out & protect_select_bit_in;
         secure_map_out      <= secure_mode_out;
         array_write_ok_out  <= ~write_block
                                & ~(secure_mode_out & protect_select_bit_in);
         secure_write_ok_out <= ~write_block & secure_mode_out & ~protect_select_bit_in
                                & (block_protection_field_in == `SFID_BP_CLEAR);
         status_view_out     <= {protect_select_bit_in, 2'h0,
                                 block_protection_field_in, 2'h0};
      end
   end
endmodule

/* File: sim/sfid_core_chk.sv */
// Concurrent checks on the ports of the identification and secure-sector core.
// Assumes a single clk_in domain with a synchronous active-high srst_in.
module sfid_core_chk (
   input wire logic clk_in, srst_in, sel_n_in, array_busy_in, sdo_oe_n_out,
   input wire logic deep_sleep_out, ready_out, secure_mode_out, secure_lock_out,
   input wire logic array_write_ok_out, secure_write_ok_out, lock_program_out,
   input wire logic deep_sleep_instr_out, status_write_req_out
);
   timeunit 1ns;
   timeprecision 100ps;
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (srst_in);
   property p_rst; $fell(srst_in) |-> sdo_oe_n_out && !deep_sleep_out && !ready_out; endproperty
   a_rst: assert property (p_rst) else $error("outputs not idle after reset");
   property p_oe_sel; sel_n_in [*6] |-> sdo_oe_n_out; endproperty
   a_oe_sel: assert property (p_oe_sel) else $error("output driven while deselected");
   property p_sleep_busy; $rose(deep_sleep_out) |-> !$past(array_busy_in, 2); endproperty
   a_sleep_busy: assert property (p_sleep_busy) else $error("sleep entered while busy");
   property p_sleep_pulse; deep_sleep_instr_out |-> ##[0:2] deep_sleep_out; endproperty
   a_sleep_pulse: assert property (p_sleep_pulse) else $error("sleep flag missing");
   property p_sleep_ready; deep_sleep_out |-> !ready_out; endproperty
   a_sleep_ready: assert property (p_sleep_ready) else $error("ready while asleep");
   property p_lock_sec; lock_program_out |-> secure_mode_out; endproperty
   a_lock_sec: assert property (p_lock_sec) else $error("lock program outside mode");
   property p_lock_blk; secure_lock_out |-> !array_write_ok_out && !secure_write_ok_out; endproperty
   a_lock_blk: assert property (p_lock_blk) else $error("write allowed when locked");
   property p_sec_ok; secure_write_ok_out |-> secure_mode_out && !secure_lock_out; endproperty
   a_sec_ok: assert property (p_sec_ok) else $error("secure write allowed wrongly");
   property p_swr_sec; status_write_req_out |-> !secure_mode_out; endproperty
   a_swr_sec: assert property (p_swr_sec) else $error("status write inside mode");
   c_lock: cover property (lock_program_out);
   c_sleep: cover property (deep_sleep_instr_out);
   c_wake: cover property ($fell(deep_sleep_out));
endmodule
bind sfid_core sfid_core_chk u_chk (.clk_in, .srst_in, .sel_n_in, .array_busy_in,
   .sdo_oe_n_out, .deep_sleep_out, .ready_out, .secure_mode_out, .secure_lock_out,
   .array_write_ok_out, .secure_write_ok_out, .lock_program_out, .deep_sleep_instr_out,
   .status_write_req_out);

/* File: sim/sfid_host.sv */
// Model of the SPI host: mode 0 frames with an 80 ns serial clock.
// Assumes the caller enters its tasks just after a clk_in rising edge.
module sfid_host (
   input  wire logic clk_in,
   input  wire logic sdo_in,
   input  wire logic sdo_oe_n_in,
   output logic      sel_n_out,
   output logic      sclk_out,
   output logic      sdi_out
);
   timeunit 1ns;
   timeprecision 100ps;
   initial begin
      sel_n_out = 1'b1;
      sclk_out = 1'b0;
      sdi_out = 1'b0;
   end
   task automatic tick(input int n);
      repeat (n) @(posedge clk_in);
      #1;
   endtask
   // Shifts ntx bits from tx[31] down, then reads nrx bits late in each high phase.
   task automatic frame(input logic [31:0] tx, input int ntx, input int nrx,
                        output logic [31:0] rx, output logic drove);
      rx = 32'h0;
      drove = 1'b0;
      sel_n_out = 1'b0;
      tick(2);
      for (int i = 0; i < ntx + nrx; i++) begin
         sdi_out = (i < ntx) ? tx[31 - i] : ~sdi_out;
         tick(4);
         sclk_out = 1'b1;
         tick(3);
         if (i >= ntx) rx = {rx[30:0], sdo_in};
         drove = drove | ~sdo_oe_n_in;
         tick(1);
         sclk_out = 1'b0;
      end
      tick(4);
      sel_n_out = 1'b1;
      // Released data line shows the inverse so a stale bit is never mistaken for data.
      sdi_out = ~sdi_out;
      tick(12);
   endtask
endmodule

/* File: sim/serial_flash_id_release_otp_tb.sv */
// Self-checking bench for the identification, release and secure-sector core.
// Assumes sfid_host drives the serial pins and the checker is bound to the core.
module serial_flash_id_release_otp_tb;
   timeunit 1ns;
   timeprecision 100ps;
   localparam logic [7:0] MFR = 8'hA6;  // Arbitrary value.
   localparam logic [7:0] DEV = 8'h3C;  // Arbitrary value.
   localparam logic [7:0] TYP = 8'h52;  // Arbitrary value.
   localparam logic [7:0] CAP = 8'h17;  // Arbitrary value.
   logic clk_in, srst_in, array_busy_in, protect_select_bit_in, drove;
   logic [2:0] block_protection_field_in;
   logic [31:0] rx;
   wire logic sel_n_in, sclk_in, sdi_in, sdo_out, sdo_oe_n_out, deep_sleep_out, ready_out;
   wire logic secure_mode_out, secure_lock_out, secure_map_out, array_write_ok_out;
   wire logic secure_write_ok_out;
   wire logic [7:0] status_view_out;
   wire logic lock_program_out, status_write_req_out, deep_sleep_instr_out;
   wire logic [7:0] opcode_out;
   int err_count, n_tests, n_lock, n_swr, n_dsi;
   sfid_core #(.MFR_ID(MFR), .DEV_ID(DEV), .MEM_TYPE(TYP), .CAPACITY(CAP),
      .PUW_CYCLES(32'd50)) uut (.clk_in, .srst_in, .sel_n_in, .sclk_in, .sdi_in,
      .array_busy_in, .block_protection_field_in, .protect_select_bit_in, .sdo_out,
      .sdo_oe_n_out, .deep_sleep_out, .ready_out, .secure_mode_out, .secure_lock_out,
      .secure_map_out, .array_write_ok_out, .secure_write_ok_out, .lock_program_out,
      .status_write_req_out, .deep_sleep_instr_out, .opcode_out, .status_view_out);
   sfid_host host (.clk_in, .sdo_in(sdo_out), .sdo_oe_n_in(sdo_oe_n_out),
      .sel_n_out(sel_n_in), .sclk_out(sclk_in), .sdi_out(sdi_in));
   initial begin
      clk_in = 1'b0;
      forever #5 clk_in = ~clk_in;
   end
   // One-cycle pulses are counted so that a scenario can judge them after its frame.
   always @(posedge clk_in) begin
      if (lock_program_out) n_lock <= n_lock + 1;
      if (status_write_req_out) n_swr <= n_swr + 1;
      if (deep_sleep_instr_out) n_dsi <= n_dsi + 1;
   end
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         err_count++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic close_out;
      if (err_count == 0 && n_tests > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   task automatic t_idle;
      check(status_view_out, 8'h00);
      check(array_write_ok_out, 1'b0);
      host.tick(60);
      check(array_write_ok_out, 1'b1);
   endtask
   task automatic t_ids;
      host.frame({8'hAB, 24'h0}, 32, 16, rx, drove);
      check(rx[15:0], {DEV, DEV});
      host.frame({8'h90, 24'h0}, 32, 32, rx, drove);
      check(rx, {MFR, DEV, MFR, DEV});
      host.frame({8'h90, 24'h1}, 32, 16, rx, drove);
      check(rx[15:0], {DEV, MFR});
      host.frame({8'h9F, 24'h0}, 8, 24, rx, drove);
      check(rx[23:0], {MFR, TYP, CAP});
      host.frame({8'h9F, 24'h0}, 8, 5, rx, drove);
      check({ready_out, sdo_oe_n_out, rx[4:0]}, {2'h3, MFR[7:3]});
   endtask
   task automatic t_busy;
      array_busy_in = 1'b1;
      host.frame({8'h9F, 24'h0}, 8, 8, rx, drove);
      check(drove, 1'b0);
      host.frame({8'hAB, 24'h0}, 32, 8, rx, drove);
      check(drove, 1'b0);
      host.frame({8'hB9, 24'h0}, 8, 0, rx, drove);
      check(deep_sleep_out, 1'b0);
      check(n_dsi, 32'h0);
      array_busy_in = 1'b0;
   endtask
   // Only 90h probes the sleep state, since 9Fh must not be sent while asleep.
   task automatic t_sleep;
      host.frame({8'hB9, 24'h0}, 8, 0, rx, drove);
      check(deep_sleep_out, 1'b1);
      check(n_dsi, 32'h1);
      host.frame({8'h90, 24'h0}, 32, 16, rx, drove);
      check(drove, 1'b0);
      host.frame({8'hAB, 24'h0}, 8, 0, rx, drove);
      host.tick(270);
      check(ready_out, 1'b0);
      host.tick(30);
      check({ready_out, deep_sleep_out}, 2'h2);
      host.frame({8'hB9, 24'h0}, 8, 0, rx, drove);
      host.frame({8'hAB, 24'h0}, 32, 8, rx, drove);
      check(rx[7:0], DEV);
      host.tick(150);
      check(ready_out, 1'b0);
      host.tick(30);
      check(ready_out, 1'b1);
   endtask
   task automatic t_secure;
      host.frame({8'h3A, 24'h0}, 8, 0, rx, drove);
      check({secure_mode_out, secure_map_out, secure_write_ok_out}, 3'h7);
      check(array_write_ok_out, 1'b1);
      block_protection_field_in = 3'h2;
      host.tick(3);
      check(secure_write_ok_out, 1'b0);
      block_protection_field_in = 3'h0;
      protect_select_bit_in = 1'b1;
      host.tick(3);
      check({secure_lock_out, array_write_ok_out}, 2'h2);
      check(status_view_out, 8'h80);
      host.frame({8'h01, 8'h00, 16'h0}, 16, 0, rx, drove);
      check(n_lock, 32'h1);
      check(n_swr, 32'h0);
      host.frame({8'h04, 24'h0}, 8, 0, rx, drove);
      check(secure_mode_out, 1'b0);
      check(opcode_out, 8'h04);
      host.frame({8'h01, 8'h5A, 16'h0}, 16, 0, rx, drove);
      check(n_swr, 32'h1);
      check(n_lock, 32'h1);
      protect_select_bit_in = 1'b0;
   endtask
   initial begin
      srst_in = 1'b1;
      array_busy_in = 1'b0;
      protect_select_bit_in = 1'b0;
      block_protection_field_in = 3'h0;
      err_count = 0;
      n_tests = 0;
      host.tick(20);
      srst_in = 1'b0;
      host.tick(6);
      t_idle();
      t_ids();
      t_busy();
      t_sleep();
      t_secure();
      close_out();
   end
   initial begin
      repeat (20000) @(posedge clk_in);
      err_count++;
      close_out();
   end
endmodule
